// ===== hdl/iap_flash_program_control.sv
// Flash in-application programming control with APB register access
// Operation
// (R1) Enabled bit set only by successful unlock; write 1 ignored, write 0 disables
// (R2) Select codes: 000 write, 001 page erase, 011 read, 110 unlock
// (R3) Software unlocks before any erase or write
// (R4) Trigger starts procedure timer; hardware clears trigger on timeout
// (R5) Software writes key registers promptly after raising trigger
// (R6) Correct key in words two to four within window sets enabled
// (R7) Write-initiate starts erase or write, held high until done
// (R8) Reads only allowed while read-enable is one
// (R9) Read-initiate starts flash read, cleared when read finishes
// (R10) Software never sets write-init, read-enable, read-init in one write
// (R11) Processor stalled while read, erase or write runs
// (R12) Writing 55H to reset key register resets whole chip
// (R13) Buffer-clear bit clears 32-word buffer, returns to zero when done
// (R14) Buffer-clear register bits 7 to 1 read zero
// (R15) Word1 high write tags address, increments, stops at 11111b
// (R16) Page erase touches only tagged addresses; the tags are kept here but not sent out in FLASH_REQ
// (R17) Erased words read 0000h; software blank-checks and repeats
// (R18) On failed verify software clears buffer then rewrites
// (R19) Software ensures low-speed clock stable before erase or write
// (R20) Data word registers two to four are 8-bit RW, reset zero; word2 low reads back the flash read word instead
// (R21) Word1 high write loads 16-bit word into buffer, increments address
// (R22) Buffer holds 32 words mapped to page bits 12 to 5
// (R23) Unlock timer length is a parameter in system cycles
// (R24) Erase and write durations are parameterised cycle counts
`timescale 1ns/100ps
`default_nettype none
module iap_flash_program_control
   import iap_pkg::*;
#(
   parameter int UNLOCK_LEN = iap_pkg::UNLOCK_CYCLES,
   parameter int PROGRAM_LEN = iap_pkg::PROGRAM_CYCLES,
   parameter int READ_LEN = iap_pkg::READ_CYCLES
)
(
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic CPU_STALL,
   output logic CHIP_RESET,
   output iap_pkg::flash_req_t FLASH_REQ,
   output logic FLASH_START,
   input wire logic [15:0] FLASH_RDATA
);
   import iap_pkg::*;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_PROGRAM = 2'b01,
      ST_READ = 2'b10,
      ST_CLEAR = 2'b11
   } state_t;

   localparam int CNT_W = 16;
   initial
   begin
      if (UNLOCK_LEN < 1 || PROGRAM_LEN < 1 || READ_LEN < 1 || UNLOCK_LEN >= 65536
          || PROGRAM_LEN >= 65536 || PAGE_WORDS < 2 || READ_LEN >= 65536)
         $error("iap_flash_program_control: timing out of range");
   end

   // Address decode used by the write paths; the read mux decodes with its own case
   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
      return a == ref_a;
   endfunction

   logic [7:0] addr_low;
   logic [4:0] addr_high;
   logic [7:0] word1_low, word1_high, word2_low, word2_high;
   logic [7:0] word3_low, word3_high, word4_low, word4_high;
   logic enabled, trigger, write_init, read_en, read_init, buf_clear;
   logic [2:0] op_sel;
   logic [7:0] reset_key;
   logic [15:0] buffer [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] tag;
   logic [CNT_W-1:0] unlock_cnt, op_cnt;
   logic [4:0] clear_idx;
   state_t state;
   logic [15:0] read_word;
   logic wr, rd, wr_ctl, key_ok, prog_go, read_go;

   assign wr = PSEL && PENABLE && PWRITE;
   assign rd = PSEL && PENABLE && !PWRITE;
   assign wr_ctl = wr && is_addr(PADDR, ADDR_OP_CONTROL);
   // Zero-wait slave; unmapped addresses answer zero with no error
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;

   // Key compare over data words two to four
   assign key_ok = word2_low == KEY2_LOW && word3_low == KEY3_LOW && word4_low == KEY4_LOW
      && word2_high == KEY2_HIGH && word3_high == KEY3_HIGH && word4_high == KEY4_HIGH; // see (R6)

   // A start only counts when issued from idle; erase and write need the unlock
   assign prog_go = wr_ctl && PWDATA[BIT_WRITE_INIT] && !write_init && state == ST_IDLE
      && enabled && (op_sel_t'(PWDATA[6:4]) == OP_WRITE
      || op_sel_t'(PWDATA[6:4]) == OP_ERASE); // see (R7)
   assign read_go = wr_ctl && PWDATA[BIT_READ_INIT] && PWDATA[BIT_READ_EN]
      && op_sel_t'(PWDATA[6:4]) == OP_READ && state == ST_IDLE; // see (R8)

   // Plain storage registers
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         word1_low <= RESET_BYTE;
         word1_high <= RESET_BYTE;
         word2_low <= RESET_BYTE;
         word2_high <= RESET_BYTE;
         word3_low <= RESET_BYTE;
         word3_high <= RESET_BYTE;
         word4_low <= RESET_BYTE;
         word4_high <= RESET_BYTE;
         reset_key <= RESET_BYTE;
      end
      else if (wr)
      begin
         case (PADDR)
            ADDR_WORD1_LOW: word1_low <= PWDATA[7:0];
            ADDR_WORD1_HIGH: word1_high <= PWDATA[7:0];
            ADDR_WORD2_LOW: word2_low <= PWDATA[7:0];
            ADDR_WORD2_HIGH: word2_high <= PWDATA[7:0]; // see (R20)
            ADDR_WORD3_LOW: word3_low <= PWDATA[7:0];
            ADDR_WORD3_HIGH: word3_high <= PWDATA[7:0];
            ADDR_WORD4_LOW: word4_low <= PWDATA[7:0];
            ADDR_WORD4_HIGH: word4_high <= PWDATA[7:0];
            ADDR_RESET_KEY: reset_key <= PWDATA[7:0];
            default: ;
         endcase
      end
   end

   // Chip reset pulse on the key value; stored value stays readable
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
         CHIP_RESET <= 1'b0;
      else
         CHIP_RESET <= wr && is_addr(PADDR, ADDR_RESET_KEY)
            && PWDATA[7:0] == CHIP_RESET_VALUE; // see (R12)
   end

   // Address pair with auto-increment that saturates at the page end
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         addr_low <= RESET_BYTE;
         addr_high <= 5'h0;
      end
      else if (wr && is_addr(PADDR, ADDR_ADDRESS_LOW))
         addr_low <= PWDATA[7:0];
      else if (wr && is_addr(PADDR, ADDR_ADDRESS_HIGH))
         addr_high <= PWDATA[4:0];
      else if (wr && is_addr(PADDR, ADDR_WORD1_HIGH) && addr_low[4:0] != PAGE_LAST)
         addr_low <= addr_low + 8'h01; // see (R15) (R21)
   end

   // Write buffer and erase tags; load on word1 high while enabled, wipe on clear (buffer word by word, tags at once)
   always_ff @(posedge CLK_SYS)
   begin
      if (state == ST_CLEAR)
         buffer[clear_idx] <= ERASED_WORD; // see (R13) (R17)
      else if (wr && is_addr(PADDR, ADDR_WORD1_HIGH) && enabled)
         buffer[addr_low[4:0]] <= {PWDATA[7:0], word1_low}; // see (R21) (R22)
   end

   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
         tag <= '0;
      else if (state == ST_CLEAR || (state == ST_PROGRAM && op_cnt == CNT_W'(1)))
         tag <= '0; // Tags clear after a finished program; buffer words keep their values
      else if (wr && is_addr(PADDR, ADDR_WORD1_HIGH) && enabled)
         tag[addr_low[4:0]] <= 1'b1; // see (R15) (R16)
   end

   // Operation control bits
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         enabled <= 1'b0;
         op_sel <= OP_WRITE;
         trigger <= 1'b0;
         read_en <= 1'b0;
      end
      else
      begin
         if (wr_ctl)
         begin
            op_sel <= PWDATA[6:4]; // see (R2)
            read_en <= PWDATA[BIT_READ_EN];
            if (!trigger && PWDATA[BIT_TRIGGER] && op_sel_t'(PWDATA[6:4]) == OP_UNLOCK)
               trigger <= 1'b1; // see (R4)
         end
         if (trigger && unlock_cnt == CNT_W'(1))
            trigger <= 1'b0; // see (R4)
         // Hardware set wins over a same-cycle software clear
         if (trigger && key_ok)
            enabled <= 1'b1; // see (R1) (R6)
         else if (wr_ctl && !PWDATA[BIT_ENABLED])
            enabled <= 1'b0; // see (R1)
      end
   end

   // Unlock window timer
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
         unlock_cnt <= '0;
      else if (wr_ctl && !trigger && PWDATA[BIT_TRIGGER] && op_sel_t'(PWDATA[6:4]) == OP_UNLOCK)
         unlock_cnt <= CNT_W'(UNLOCK_LEN); // see (R23)
      else if (unlock_cnt != '0)
         unlock_cnt <= unlock_cnt - CNT_W'(1);
   end

   // Operation sequencer for program, read and buffer clear
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         state <= ST_IDLE;
         op_cnt <= '0;
         clear_idx <= 5'h0;
         write_init <= 1'b0;
         read_init <= 1'b0;
         buf_clear <= 1'b0;
         read_word <= ERASED_WORD;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (prog_go)
               begin
                  state <= ST_PROGRAM;
                  write_init <= 1'b1; // see (R7)
                  op_cnt <= CNT_W'(PROGRAM_LEN); // see (R24)
               end
               else if (read_go)
               begin
                  state <= ST_READ;
                  read_init <= 1'b1; // see (R9)
                  op_cnt <= CNT_W'(READ_LEN);
               end
               else if (wr && is_addr(PADDR, ADDR_BUF_CLEAR) && PWDATA[BIT_BUF_CLEAR])
               begin
                  state <= ST_CLEAR;
                  buf_clear <= 1'b1; // see (R13)
                  clear_idx <= 5'h0;
               end
            end
            ST_PROGRAM:
            begin
               op_cnt <= op_cnt - CNT_W'(1);
               if (op_cnt == CNT_W'(1))
               begin
                  write_init <= 1'b0; // see (R7)
                  state <= ST_IDLE;
               end
            end
            ST_READ:
            begin
               op_cnt <= op_cnt - CNT_W'(1);
               if (op_cnt == CNT_W'(1))
               begin
                  read_word <= FLASH_RDATA;
                  read_init <= 1'b0; // see (R9)
                  state <= ST_IDLE;
               end
            end
            ST_CLEAR:
            begin
               clear_idx <= clear_idx + 5'h1;
               if (clear_idx == PAGE_LAST)
               begin
                  buf_clear <= 1'b0; // see (R13)
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Request towards the flash array; the tag mask held by this block is not part of the request
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         FLASH_REQ <= '0;
         FLASH_START <= 1'b0;
      end
      else
      begin
         FLASH_START <= prog_go || read_go;
         if (prog_go || read_go)
         begin
            FLASH_REQ.erase <= op_sel_t'(PWDATA[6:4]) == OP_ERASE; // see (R16)
            FLASH_REQ.write <= op_sel_t'(PWDATA[6:4]) == OP_WRITE;
            FLASH_REQ.read <= read_go;
            FLASH_REQ.address <= {addr_high, addr_low};
            FLASH_REQ.data <= buffer[addr_low[4:0]];
         end
      end
   end

   // Stall covers the whole operation, from start edge to completion
   assign CPU_STALL = state == ST_PROGRAM || state == ST_READ; // see (R11)

   // Read mux; unmapped reads return zero
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
         PRDATA <= 32'h0000_0000;
      else if (PSEL && !PENABLE && !PWRITE)
      begin
         case (PADDR)
            ADDR_ADDRESS_LOW: PRDATA <= {24'h00_0000, addr_low};
            ADDR_ADDRESS_HIGH: PRDATA <= {27'h000_0000, addr_high};
            ADDR_WORD1_LOW: PRDATA <= {24'h00_0000, word1_low};
            ADDR_WORD1_HIGH: PRDATA <= {24'h00_0000, word1_high};
            ADDR_WORD2_LOW: PRDATA <= {16'h0000, read_word};
            ADDR_WORD2_HIGH: PRDATA <= {24'h00_0000, word2_high};
            ADDR_WORD3_LOW: PRDATA <= {24'h00_0000, word3_low};
            ADDR_WORD3_HIGH: PRDATA <= {24'h00_0000, word3_high};
            ADDR_WORD4_LOW: PRDATA <= {24'h00_0000, word4_low};
            ADDR_WORD4_HIGH: PRDATA <= {24'h00_0000, word4_high};
            ADDR_OP_CONTROL: PRDATA <= {24'h00_0000, enabled, op_sel, trigger, write_init,
                                        read_en, read_init};
            ADDR_RESET_KEY: PRDATA <= {24'h00_0000, reset_key};
            ADDR_BUF_CLEAR: PRDATA <= {31'h0000_0000, buf_clear}; // see (R14)
            default: PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // Assertions; a long repetition would be unrolled, so clear length is counted instead
   logic [5:0] clear_age;
   always_ff @(posedge CLK_SYS or negedge NRST)
      if (!NRST)
         clear_age <= 6'h00;
      else
         clear_age <= buf_clear ? clear_age + 6'h01 : 6'h00;
   sequence s_unlock_start;
      wr_ctl && !trigger && PWDATA[BIT_TRIGGER] && op_sel_t'(PWDATA[6:4]) == OP_UNLOCK;
   endsequence
   property p_enable_cause;
      @(posedge CLK_SYS) disable iff (!NRST) $rose(enabled) |-> $past(trigger && key_ok);
   endproperty
   a_enable_cause: assert property (p_enable_cause) else $error("enabled set without key"); // see (R1)
   property p_enable_clear;
      @(posedge CLK_SYS) disable iff (!NRST)
         wr_ctl && !PWDATA[BIT_ENABLED] && !(trigger && key_ok) |=> !enabled;
   endproperty
   a_enable_clear: assert property (p_enable_clear) else $error("enabled not cleared"); // see (R1)
   property p_trigger_window;
      @(posedge CLK_SYS) disable iff (!NRST) s_unlock_start |=> trigger && unlock_cnt != '0;
   endproperty
   a_trigger_window: assert property (p_trigger_window) else $error("trigger not started"); // see (R4)
   property p_write_hold;
      @(posedge CLK_SYS) disable iff (!NRST) prog_go |=> write_init [*8];
   endproperty
   a_write_hold: assert property (p_write_hold) else $error("write initiate dropped early"); // see (R7)
   property p_write_end;
      @(posedge CLK_SYS) disable iff (!NRST) $fell(write_init) |-> $past(op_cnt) == CNT_W'(1);
   endproperty
   a_write_end: assert property (p_write_end) else $error("write ended at wrong count"); // see (R24)
   property p_read_gate;
      @(posedge CLK_SYS) disable iff (!NRST) $rose(read_init) |-> read_en;
   endproperty
   a_read_gate: assert property (p_read_gate) else $error("read without enable"); // see (R8)
   property p_stall;
      @(posedge CLK_SYS) disable iff (!NRST) (write_init || read_init) |-> CPU_STALL;
   endproperty
   a_stall: assert property (p_stall) else $error("cpu not stalled"); // see (R11)
   property p_chip_reset;
      @(posedge CLK_SYS) disable iff (!NRST)
         wr && is_addr(PADDR, ADDR_RESET_KEY) && PWDATA[7:0] == CHIP_RESET_VALUE |=> CHIP_RESET;
   endproperty
   a_chip_reset: assert property (p_chip_reset) else $error("no chip reset"); // see (R12)
   property p_clear_len;
      @(posedge CLK_SYS) disable iff (!NRST) $fell(buf_clear) |-> clear_age == 6'(PAGE_WORDS);
   endproperty
   a_clear_len: assert property (p_clear_len) else $error("buffer clear length wrong"); // see (R13)
   property p_addr_sat;
      @(posedge CLK_SYS) disable iff (!NRST)
         wr && is_addr(PADDR, ADDR_WORD1_HIGH) && addr_low[4:0] == PAGE_LAST
         |=> addr_low[4:0] == PAGE_LAST;
   endproperty
   a_addr_sat: assert property (p_addr_sat) else $error("address passed page end"); // see (R15)
endmodule // iap_flash_program_control
`default_nettype wire

// ===== hdl/iap_pkg.sv
// Package with register map, field positions and timing for the flash programming control
package iap_pkg;
   // Register byte addresses on APB (one aligned word each)
   localparam logic [7:0] ADDR_ADDRESS_LOW = 8'h00;
   localparam logic [7:0] ADDR_ADDRESS_HIGH = 8'h04;
   localparam logic [7:0] ADDR_WORD1_LOW = 8'h08;
   localparam logic [7:0] ADDR_WORD1_HIGH = 8'h0C;
   localparam logic [7:0] ADDR_WORD2_LOW = 8'h10;
   localparam logic [7:0] ADDR_WORD2_HIGH = 8'h14;
   localparam logic [7:0] ADDR_WORD3_LOW = 8'h18;
   localparam logic [7:0] ADDR_WORD3_HIGH = 8'h1C;
   localparam logic [7:0] ADDR_WORD4_LOW = 8'h20;
   localparam logic [7:0] ADDR_WORD4_HIGH = 8'h24;
   localparam logic [7:0] ADDR_OP_CONTROL = 8'h28;
   localparam logic [7:0] ADDR_RESET_KEY = 8'h2C;
   localparam logic [7:0] ADDR_BUF_CLEAR = 8'h30;
   // Operation control field positions
   localparam int BIT_ENABLED = 7;
   localparam int BIT_TRIGGER = 3;
   localparam int BIT_WRITE_INIT = 2;
   localparam int BIT_READ_EN = 1;
   localparam int BIT_READ_INIT = 0;
   localparam int BIT_BUF_CLEAR = 0;
   // Operation select codes
   typedef enum logic [2:0]
   {
      OP_WRITE = 3'b000,
      OP_ERASE = 3'b001,
      OP_READ = 3'b011,
      OP_UNLOCK = 3'b110
   } op_sel_t;
   // Unlock key, words two to four
   localparam logic [7:0] KEY2_LOW = 8'h00;
   localparam logic [7:0] KEY3_LOW = 8'h0D;
   localparam logic [7:0] KEY4_LOW = 8'hC3;
   localparam logic [7:0] KEY2_HIGH = 8'h04;
   localparam logic [7:0] KEY3_HIGH = 8'h09;
   localparam logic [7:0] KEY4_HIGH = 8'h40;
   localparam logic [7:0] CHIP_RESET_VALUE = 8'h55;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [4:0] PAGE_LAST = 5'b1_1111;
   localparam logic [15:0] ERASED_WORD = 16'h0000;
   // Default timings in cycles at 200 MHz
   localparam int UNLOCK_CYCLES = 1024;
   localparam int PROGRAM_CYCLES = 2048;
   localparam int READ_CYCLES = 4;
   localparam int PAGE_WORDS = 32;
   // Flash array request carried out of the block
   typedef struct packed
   {
      logic erase;
      logic write;
      logic read;
      logic [12:0] address;
      logic [15:0] data;
   } flash_req_t;
endpackage

// ===== bench/iap_flash_program_control_tb.sv
// Self-checking testbench for the flash programming control over APB
`timescale 1ns/100ps
`default_nettype none
module iap_flash_program_control_tb;
   import iap_pkg::*;
   // Shortened timer and program lengths keep the run brief
   localparam int UL = 40;
   localparam int PL = 10;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, stall, chip_rst, fstart;
   flash_req_t freq, last_req;
   logic [15:0] frdata = 16'h0000;
   int miscompares = 0;
   int samples_checked = 0;
   int starts = 0;
   int resets = 0;
   int n;
   logic [31:0] seed = 32'hdacf69f5;
   logic [31:0] r, d, pg;
   logic [7:0] rw_regs [5] = '{ADDR_WORD2_HIGH, ADDR_WORD3_LOW, ADDR_WORD3_HIGH,
      ADDR_WORD4_LOW, ADDR_WORD4_HIGH};
   logic [2:0] rsv [4] = '{3'b010, 3'b100, 3'b101, 3'b111};

   // Free-running system clock, 5 ns period
   always #2.5 clk = ~clk;

   iap_flash_program_control #(.UNLOCK_LEN(UL), .PROGRAM_LEN(PL), .READ_LEN(4))
   iap_flash_program_control_i
   (
      .CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CPU_STALL(stall), .CHIP_RESET(chip_rst),
      .FLASH_REQ(freq), .FLASH_START(fstart), .FLASH_RDATA(frdata)
   );

   // Pulses are counted here so a short pulse is never missed between bus cycles
   always @(posedge clk)
   begin
      if (fstart === 1'b1)
      begin
         starts <= starts + 1;
         last_req <= freq;
      end
      if (chip_rst === 1'b1)
         resets <= resets + 1;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected address after a tagging write: stops at the page's last word
   function automatic logic [31:0] next_addr(input logic [31:0] a);
      return (a[4:0] == 5'h1F) ? a : a + 32'h0000_0001;
   endfunction

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat,
      output logic [31:0] rv);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      rv = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      logic [31:0] rv;
      apb(1'b1, a, dat, rv);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t %s got %b exp %b", $time, m, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
      logic [31:0] rv;
      apb(1'b0, a, 32'h0000_0000, rv);
      chk(rv, exp, m);
   endtask

   // Polls a self-clearing bit with a bounded number of reads
   task automatic wait_low(input logic [7:0] a, input int b);
      logic [31:0] rv;
      int k;
      k = 0;
      do
      begin
         apb(1'b0, a, 32'h0000_0000, rv);
         k++;
      end
      while (rv[b] !== 1'b0 && k < 100);
      chk1(rv[b], 1'b0, "self clearing bit");
   endtask

   task automatic unlock(input logic [7:0] bad);
      logic [31:0] rv;
      wr(ADDR_OP_CONTROL, 32'h0000_0068);
      wr(ADDR_WORD2_LOW, {24'h00_0000, KEY2_LOW ^ bad});
      wr(ADDR_WORD3_LOW, {24'h00_0000, KEY3_LOW});
      wr(ADDR_WORD4_LOW, {24'h00_0000, KEY4_LOW});
      wr(ADDR_WORD2_HIGH, {24'h00_0000, KEY2_HIGH});
      wr(ADDR_WORD3_HIGH, {24'h00_0000, KEY3_HIGH});
      wr(ADDR_WORD4_HIGH, {24'h00_0000, KEY4_HIGH});
      apb(1'b0, ADDR_OP_CONTROL, 32'h0000_0000, rv);
      chk1(rv[BIT_TRIGGER], 1'b1, "trigger running");
      chk1(rv[BIT_ENABLED], bad == 8'h00, "enabled after key");
      wait_low(ADDR_OP_CONTROL, BIT_TRIGGER);
   endtask

   task automatic give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog sized well beyond the expected run length
   initial
   begin
      repeat (40000) @(posedge clk);
      miscompares++;
      give_verdict();
   end

   // Main sequence: reset, register checks, unlock, program, read, clear, chip reset
   initial
   begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      foreach (rw_regs[i]) rdchk(rw_regs[i], 32'h0000_0000, "reset value");
      rdchk(ADDR_OP_CONTROL, 32'h0000_0000, "control reset");
      rdchk(ADDR_BUF_CLEAR, 32'h0000_0000, "clear reset");
      for (int j = 0; j < 4; j++)
         foreach (rw_regs[i])
         begin
            seed = lfsr(seed);
            wr(rw_regs[i], {24'h00_0000, seed[7:0]});
            rdchk(rw_regs[i], {24'h00_0000, seed[7:0]}, "byte register");
         end
      d = {24'h00_0000, seed[15:8] == CHIP_RESET_VALUE ? 8'h54 : seed[15:8]};
      n = resets;
      wr(ADDR_RESET_KEY, d);
      rdchk(ADDR_RESET_KEY, d, "key store");
      wr(8'h3C, 32'h0000_00FF);
      rdchk(8'h3C, 32'h0000_0000, "unmapped");
      wr(ADDR_OP_CONTROL, 32'h0000_0080);
      rdchk(ADDR_OP_CONTROL, 32'h0000_0000, "software set of enabled");
      chk1(pslverr, 1'b0, "no error response");
      $display("test registers done");
      unlock(8'h01);
      unlock(8'h00);
      $display("test unlock done");
      foreach (rsv[i])
      begin
         n = starts;
         wr(ADDR_OP_CONTROL, {24'h00_0000, 1'b1, rsv[i], 4'b0100});
         #1;
         chk1(stall, 1'b0, "reserved mode stall");
         repeat (3) @(posedge clk);
         chk(starts, n, "reserved mode start");
      end
      seed = lfsr(seed);
      pg = {24'h00_0000, seed[7:5], 5'h00};
      wr(ADDR_ADDRESS_LOW, pg);
      wr(ADDR_WORD1_HIGH, 32'h0000_0000);
      n = starts;
      wr(ADDR_OP_CONTROL, 32'h0000_0094);
      #1;
      chk1(stall, 1'b1, "erase stall");
      rdchk(ADDR_OP_CONTROL, 32'h0000_0094, "erase running");
      wait_low(ADDR_OP_CONTROL, BIT_WRITE_INIT);
      chk1(stall, 1'b0, "erase stall end");
      chk(starts, n + 1, "erase start");
      chk1(last_req.erase, 1'b1, "erase kind");
      chk({19'h0_0000, last_req.address}, pg + 32'h0000_0001, "erase address");
      pg = pg | 32'h0000_001E;
      wr(ADDR_ADDRESS_LOW, pg);
      for (int j = 0; j < 2; j++)
      begin
         seed = lfsr(seed);
         wr(ADDR_WORD1_LOW, {24'h00_0000, seed[7:0]});
         wr(ADDR_WORD1_HIGH, {24'h00_0000, seed[15:8]});
         pg = next_addr(pg);
         rdchk(ADDR_ADDRESS_LOW, pg, "address step");
      end
      n = starts;
      wr(ADDR_OP_CONTROL, 32'h0000_0084);
      wait_low(ADDR_OP_CONTROL, BIT_WRITE_INIT);
      chk(starts, n + 1, "write start");
      chk1(last_req.write, 1'b1, "write kind");
      chk({19'h0_0000, last_req.address}, pg, "write address");
      chk({16'h0000, last_req.data}, {16'h0000, seed[15:0]}, "write data");
      $display("test program done");
      wr(ADDR_OP_CONTROL, 32'h0000_0000);
      rdchk(ADDR_OP_CONTROL, 32'h0000_0000, "software clear");
      n = starts;
      wr(ADDR_OP_CONTROL, 32'h0000_0004);
      #1;
      chk1(stall, 1'b0, "locked program");
      wr(ADDR_OP_CONTROL, 32'h0000_0031);
      #1;
      chk1(stall, 1'b0, "read disabled");
      repeat (3) @(posedge clk);
      chk(starts, n, "refused starts");
      seed = lfsr(seed);
      frdata <= seed[15:0];
      wr(ADDR_OP_CONTROL, 32'h0000_0033);
      #1;
      chk1(stall, 1'b1, "read stall");
      wait_low(ADDR_OP_CONTROL, BIT_READ_INIT);
      chk1(last_req.read, 1'b1, "read kind");
      rdchk(ADDR_WORD2_LOW, {16'h0000, seed[15:0]}, "read word");
      $display("test read done");
      wr(ADDR_BUF_CLEAR, 32'h0000_00FF);
      rdchk(ADDR_BUF_CLEAR, 32'h0000_0001, "clear running");
      wait_low(ADDR_BUF_CLEAR, BIT_BUF_CLEAR);
      rdchk(ADDR_BUF_CLEAR, 32'h0000_0000, "clear done");
      n = resets;
      wr(ADDR_RESET_KEY, {24'h00_0000, CHIP_RESET_VALUE});
      repeat (3) @(posedge clk);
      chk(resets, n + 1, "chip reset pulse");
      $display("test clear and reset done");
      give_verdict();
   end
endmodule // iap_flash_program_control_tb
`default_nettype wire
